// >>> hw/dma_ctl_regs.svh
// constants of the dma control block: opcodes, layouts, reset values
`ifndef DMA_CTL_REGS_SVH
`define DMA_CTL_REGS_SVH

// link opcodes
`define OP_NOP        4'h0
`define OP_BASE_SET   4'h1
`define OP_BASE_GET   4'h2
`define OP_ALT_GET    4'h3
`define OP_CTL_EN     4'h4
`define OP_CTL_DIS    4'h5
`define OP_ERR_GET    4'h6
`define OP_ERR_CLR    4'h7
`define OP_INT_GET    4'h8
`define OP_INT_CLR    4'h9
`define OP_CH_EN      4'hA
`define OP_CH_REQ     4'hB
`define OP_CH_ISEN    4'hC

// table layout
`define ALIGN_MASK    32'hFFFF_FC00
`define ALT_OFFSET    32'h0000_0200
`define STRUCT_SHIFT  4
`define SRC_OFF       32'h0000_0000
`define DST_OFF       32'h0000_0004
`define CTL_OFF       32'h0000_0008
`define WORD_STEP     32'h0000_0004
`define BASE_RST      32'h0000_0000

// control word fields
`define MODE_MSB      2
`define CNT_LSB       4
`define CNT_MSB       13
`define CTRL_KEEP     32'hFFFF_C008
`define MODE_STOP     3'h0
`define MODE_BASIC    3'h1
`define MODE_AUTO     3'h2

// channels and buffering
`define SW_CH         5'h1E
`define CH_MSB        4
`define FIFO_WIDTH    32
`define FIFO_DEPTH    32

`endif

// >>> hw/dma_ctl_pkg.sv
// types shared by both ends of the dma control link
package dma_ctl_pkg;
`include "dma_ctl_regs.svh"

	typedef enum logic [3:0] {
		OP_NOP      = `OP_NOP,
		OP_BASE_SET = `OP_BASE_SET,
		OP_BASE_GET = `OP_BASE_GET,
		OP_ALT_GET  = `OP_ALT_GET,
		OP_CTL_EN   = `OP_CTL_EN,
		OP_CTL_DIS  = `OP_CTL_DIS,
		OP_ERR_GET  = `OP_ERR_GET,
		OP_ERR_CLR  = `OP_ERR_CLR,
		OP_INT_GET  = `OP_INT_GET,
		OP_INT_CLR  = `OP_INT_CLR,
		OP_CH_EN    = `OP_CH_EN,
		OP_CH_REQ   = `OP_CH_REQ,
		OP_CH_ISEN  = `OP_CH_ISEN
	} op_t;

	// gray along idle, fetch src, dst, ctrl, move, write back, done
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FSRC  = 3'h1,
		ST_FDST  = 3'h3,
		ST_FCTL  = 3'h2,
		ST_MOVE  = 3'h6,
		ST_WBACK = 3'h7,
		ST_DONE  = 3'h5
	} st_t;

endpackage : dma_ctl_pkg

// >>> hw/dma_link_if.sv
// command link between the processor-side end and the dma controller
interface dma_link_if;
	logic               req_valid;
	logic               req_ready;
	dma_ctl_pkg::op_t   req_op;
	logic [31:0]        req_data;
	logic               rsp_valid;
	logic [31:0]        rsp_data;

	modport dev (
		input  req_valid,
		output req_ready,
		input  req_op,
		input  req_data,
		output rsp_valid,
		output rsp_data
	);

	modport host (
		output req_valid,
		input  req_ready,
		output req_op,
		output req_data,
		input  rsp_valid,
		input  rsp_data
	);
endinterface : dma_link_if

// >>> hw/dma_ctl_device.sv
// dma controller end: table pointer, global enable, irq status, engine
// Notes on behaviour
// - table base is 1024-byte aligned
// - channel control fetched from table at base
// - alternate structures in upper half, reported
// - software sets base before channel use
// - software sizes table by channels and modes
// - global enable low stops all activity
// - software enables controller before channel setup
// - error status nonzero while error pending
// - clearing error status drops error irq
// - write one clears channel irq bit
// - status read shows all completed channels
// - channel 30 completion on software irq
// - separate error irq output
// - peripheral channel completion on peripheral signal
// - auto mode runs to end after request
// - software enables channel then requests it; the host end passes OP_CH_REQ without checking the channel enable
// - completion clears channel enable
// - completion writes stopped mode to structure

`include "dma_ctl_regs.svh"

// word buffer between read and write sides of the engine
module dma_fifo #(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             clr,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	// honest full and empty straight from the count
	assign in_ready  = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointer and count next values
	always_comb begin
		wp_nxt  = wp_r + AW'(push);
		rp_nxt  = rp_r + AW'(pop);
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		if (clr) begin
			wp_nxt  = '0;
			rp_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	// registers; the array itself has no reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
			if (push)
				mem_r[wp_r] <= in_data;
		end
	end
endmodule : dma_fifo

module dma_ctl_device (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	dma_link_if.dev          link,
	input  wire logic [31:0] chan_req,
	output logic             mem_rd_req,
	output logic      [31:0] mem_rd_addr,
	input  wire logic        mem_rd_valid,
	input  wire logic [31:0] mem_rd_data,
	output logic             mem_wr_req,
	output logic      [31:0] mem_wr_addr,
	output logic      [31:0] mem_wr_data,
	input  wire logic        mem_wr_ready,
	input  wire logic        mem_err,
	output logic             sw_irq,
	output logic             err_irq,
	output logic      [31:0] periph_done
);
	dma_ctl_pkg::st_t state_r, state_nxt;
	logic [31:0] base_r, base_nxt, src_r, src_nxt, dst_r, dst_nxt;
	logic [31:0] ctrl_r, ctrl_nxt, en_r, en_nxt, swreq_r, swreq_nxt;
	logic [31:0] chis_r, chis_nxt, done_r, done_nxt, rsp_data_r;
	logic [31:0] rsp_data_nxt;
	logic [10:0] rd_left_r, rd_left_nxt, wr_left_r, wr_left_nxt;
	logic [`CH_MSB:0] ch_r, ch_nxt;
	logic        glb_en_r, glb_en_nxt, err_r, err_nxt;
	logic        rsp_valid_r, rsp_valid_nxt;
	logic        f_in_ready, f_out_valid, f_out_ready, f_in_valid;
	logic        fifo_clr, pick_found, req_ok;
	logic [31:0] f_out_data, ready_ch;
	logic [`CH_MSB:0] pick_idx;

	// address of a word in a channel's primary structure
	function automatic logic [31:0] struct_addr(input logic [31:0] base,
		input logic [`CH_MSB:0] ch, input logic [31:0] off);
		struct_addr = base + (32'(ch) << `STRUCT_SHIFT) + off;
	endfunction : struct_addr

	// lowest numbered enabled channel with a request
	function automatic logic [`CH_MSB+1:0] lowest(input logic [31:0] v);
		lowest = '0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i])
				lowest = {1'b1, i[`CH_MSB:0]};
		end
	endfunction : lowest

	assign ready_ch = en_r & (chan_req | swreq_r);
	assign {pick_found, pick_idx} = lowest(ready_ch);
	assign req_ok = ctrl_r[`MODE_MSB:0] == `MODE_AUTO || chan_req[ch_r];

	// memory handshakes; nothing is asked while disabled or frozen
	always_comb begin
		mem_rd_req = 1'b0;
		mem_wr_req = 1'b0;
		if (glb_en_r && ce) begin
			case (state_r)
				dma_ctl_pkg::ST_FSRC,
				dma_ctl_pkg::ST_FDST,
				dma_ctl_pkg::ST_FCTL: mem_rd_req = 1'b1;
				dma_ctl_pkg::ST_MOVE: begin
					mem_rd_req = rd_left_r != '0 && f_in_ready && req_ok;
					mem_wr_req = f_out_valid;
				end
				dma_ctl_pkg::ST_WBACK: mem_wr_req = 1'b1;
				default: ;
			endcase
		end
	end

	// addresses and write data from held pointers
	always_comb begin
		case (state_r)
			dma_ctl_pkg::ST_FSRC: mem_rd_addr = struct_addr(base_r, ch_r, `SRC_OFF);
			dma_ctl_pkg::ST_FDST: mem_rd_addr = struct_addr(base_r, ch_r, `DST_OFF);
			dma_ctl_pkg::ST_FCTL: mem_rd_addr = struct_addr(base_r, ch_r, `CTL_OFF);
			default:              mem_rd_addr = src_r;
		endcase
		if (state_r == dma_ctl_pkg::ST_WBACK) begin
			mem_wr_addr = struct_addr(base_r, ch_r, `CTL_OFF);
			// mode becomes stopped, count field emptied
			mem_wr_data = (ctrl_r & `CTRL_KEEP) | 32'(`MODE_STOP);
		end else begin
			mem_wr_addr = dst_r;
			mem_wr_data = f_out_data;
		end
	end

	assign f_in_valid  = state_r == dma_ctl_pkg::ST_MOVE && mem_rd_req &&
		mem_rd_valid;
	assign f_out_ready = state_r == dma_ctl_pkg::ST_MOVE && mem_wr_req &&
		mem_wr_ready;
	assign link.req_ready = !rsp_valid_r;
	assign link.rsp_valid = rsp_valid_r;
	assign link.rsp_data  = rsp_data_r;
	assign sw_irq         = chis_r[`SW_CH];
	assign err_irq        = err_r;
	assign periph_done    = done_r;

	dma_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.clr       (fifo_clr),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (mem_rd_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// engine then commands; hardware sets are applied last so they win
	always_comb begin
		logic [31:0] chis_set;
		logic [31:0] en_clr;
		logic        err_set;
		chis_set      = '0;
		en_clr        = '0;
		err_set       = 1'b0;
		state_nxt     = state_r;
		base_nxt      = base_r;
		src_nxt       = src_r;
		dst_nxt       = dst_r;
		ctrl_nxt      = ctrl_r;
		ch_nxt        = ch_r;
		rd_left_nxt   = rd_left_r;
		wr_left_nxt   = wr_left_r;
		swreq_nxt     = swreq_r;
		glb_en_nxt    = glb_en_r;
		done_nxt      = '0;
		fifo_clr      = 1'b0;
		rsp_valid_nxt = 1'b0;
		rsp_data_nxt  = rsp_data_r;
		if (glb_en_r) begin
			case (state_r)
				dma_ctl_pkg::ST_IDLE: if (pick_found) begin
					ch_nxt              = pick_idx;
					swreq_nxt[pick_idx] = 1'b0;
					state_nxt           = dma_ctl_pkg::ST_FSRC;
				end
				dma_ctl_pkg::ST_FSRC: if (mem_rd_valid) begin
					src_nxt   = mem_rd_data;
					state_nxt = dma_ctl_pkg::ST_FDST;
				end
				dma_ctl_pkg::ST_FDST: if (mem_rd_valid) begin
					dst_nxt   = mem_rd_data;
					state_nxt = dma_ctl_pkg::ST_FCTL;
				end
				dma_ctl_pkg::ST_FCTL: if (mem_rd_valid) begin
					ctrl_nxt    = mem_rd_data;
					rd_left_nxt = 11'(mem_rd_data[`CNT_MSB:`CNT_LSB]) + 11'h001;
					wr_left_nxt = 11'(mem_rd_data[`CNT_MSB:`CNT_LSB]) + 11'h001;
					if (mem_rd_data[`MODE_MSB:0] == `MODE_STOP) begin
						en_clr[ch_r] = 1'b1; // stopped structure: nothing to move
						state_nxt    = dma_ctl_pkg::ST_IDLE;
					end else
						state_nxt = dma_ctl_pkg::ST_MOVE;
				end
				dma_ctl_pkg::ST_MOVE: begin
					if (f_in_valid) begin
						src_nxt     = src_r + `WORD_STEP;
						rd_left_nxt = rd_left_r - 11'h001;
					end
					if (f_out_ready) begin
						dst_nxt     = dst_r + `WORD_STEP;
						wr_left_nxt = wr_left_r - 11'h001;
						if (wr_left_r == 11'h001)
							state_nxt = dma_ctl_pkg::ST_WBACK;
					end
				end
				dma_ctl_pkg::ST_WBACK: if (mem_wr_ready)
					state_nxt = dma_ctl_pkg::ST_DONE;
				dma_ctl_pkg::ST_DONE: begin
					en_clr[ch_r]   = 1'b1;
					chis_set[ch_r] = 1'b1;
					if (ch_r != `SW_CH)
						done_nxt[ch_r] = 1'b1;
					state_nxt = dma_ctl_pkg::ST_IDLE;
				end
				default: state_nxt = dma_ctl_pkg::ST_IDLE;
			endcase
			// a bus error aborts the transfer and leaves the channel off
			if (mem_err && state_r != dma_ctl_pkg::ST_IDLE) begin
				err_set      = 1'b1;
				en_clr[ch_r] = 1'b1;
				fifo_clr     = 1'b1;
				state_nxt    = dma_ctl_pkg::ST_IDLE;
			end
		end
		en_nxt   = en_r & ~en_clr;
		chis_nxt = chis_r;
		err_nxt  = err_r;
		if (link.req_valid && link.req_ready) begin
			rsp_valid_nxt = 1'b1;
			rsp_data_nxt  = '0;
			case (link.req_op)
				dma_ctl_pkg::OP_BASE_SET:
					base_nxt = link.req_data & `ALIGN_MASK;
				dma_ctl_pkg::OP_BASE_GET: rsp_data_nxt = base_r;
				dma_ctl_pkg::OP_ALT_GET:
					rsp_data_nxt = base_r + `ALT_OFFSET;
				dma_ctl_pkg::OP_CTL_EN:  glb_en_nxt = 1'b1;
				dma_ctl_pkg::OP_CTL_DIS: glb_en_nxt = 1'b0;
				dma_ctl_pkg::OP_ERR_GET: rsp_data_nxt = 32'(err_r);
				dma_ctl_pkg::OP_ERR_CLR: err_nxt = 1'b0;
				dma_ctl_pkg::OP_INT_GET: rsp_data_nxt = chis_r;
				dma_ctl_pkg::OP_INT_CLR:
					chis_nxt = chis_r & ~link.req_data;
				dma_ctl_pkg::OP_CH_EN:
					en_nxt[link.req_data[`CH_MSB:0]] = 1'b1;
				dma_ctl_pkg::OP_CH_REQ:
					swreq_nxt[link.req_data[`CH_MSB:0]] = 1'b1;
				dma_ctl_pkg::OP_CH_ISEN:
					rsp_data_nxt = 32'(en_r[link.req_data[`CH_MSB:0]]);
				default: ;
			endcase
		end
		chis_nxt = chis_nxt | chis_set;
		err_nxt  = err_nxt | err_set;
	end

	// registers only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r     <= dma_ctl_pkg::ST_IDLE;
			base_r      <= `BASE_RST;
			src_r       <= '0;
			dst_r       <= '0;
			ctrl_r      <= '0;
			ch_r        <= '0;
			rd_left_r   <= '0;
			wr_left_r   <= '0;
			en_r        <= '0;
			swreq_r     <= '0;
			chis_r      <= '0;
			done_r      <= '0;
			glb_en_r    <= 1'b0;
			err_r       <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= '0;
		end else if (ce) begin
			state_r     <= state_nxt;
			base_r      <= base_nxt;
			src_r       <= src_nxt;
			dst_r       <= dst_nxt;
			ctrl_r      <= ctrl_nxt;
			ch_r        <= ch_nxt;
			rd_left_r   <= rd_left_nxt;
			wr_left_r   <= wr_left_nxt;
			en_r        <= en_nxt;
			swreq_r     <= swreq_nxt;
			chis_r      <= chis_nxt;
			done_r      <= done_nxt;
			glb_en_r    <= glb_en_nxt;
			err_r       <= err_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			rsp_data_r  <= rsp_data_nxt;
		end
	end
endmodule : dma_ctl_device

// >>> hw/dma_ctl_host.sv
// processor-side end: issues link commands and refuses channel commands until base set and controller enabled
`include "dma_ctl_regs.svh"

module dma_ctl_host (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	dma_link_if.host               link,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire dma_ctl_pkg::op_t  cmd_op,
	input  wire logic [31:0]       cmd_data,
	output logic                   res_valid,
	output logic      [31:0]       res_data,
	output logic                   res_refused
);
	logic             req_valid_r, req_valid_nxt, busy_r, busy_nxt;
	logic             base_ok_r, base_ok_nxt, en_ok_r, en_ok_nxt;
	logic             res_valid_r, res_valid_nxt, refused_r, refused_nxt;
	logic [31:0]      req_data_r, req_data_nxt, res_data_r, res_data_nxt;
	dma_ctl_pkg::op_t req_op_r, req_op_nxt;
	logic             chan_op;

	assign cmd_ready      = !busy_r;
	assign link.req_valid = req_valid_r;
	assign link.req_op    = req_op_r;
	assign link.req_data  = req_data_r;
	assign res_valid      = res_valid_r;
	assign res_data       = res_data_r;
	assign res_refused    = refused_r;
	assign chan_op = cmd_op == dma_ctl_pkg::OP_CH_EN ||
		cmd_op == dma_ctl_pkg::OP_CH_REQ || cmd_op == dma_ctl_pkg::OP_CH_ISEN;

	// one command in flight; refused ones never reach the link
	always_comb begin
		req_valid_nxt = req_valid_r;
		req_op_nxt    = req_op_r;
		req_data_nxt  = req_data_r;
		busy_nxt      = busy_r;
		base_ok_nxt   = base_ok_r;
		en_ok_nxt     = en_ok_r;
		res_valid_nxt = 1'b0;
		res_data_nxt  = res_data_r;
		refused_nxt   = 1'b0;
		if (req_valid_r && link.req_ready)
			req_valid_nxt = 1'b0;
		if (link.rsp_valid && busy_r) begin
			busy_nxt      = 1'b0;
			res_valid_nxt = 1'b1;
			res_data_nxt  = link.rsp_data;
		end
		if (cmd_valid && cmd_ready) begin
			if ((cmd_op == dma_ctl_pkg::OP_BASE_SET &&
					(cmd_data & ~`ALIGN_MASK) != '0) ||
					(chan_op && !base_ok_r) ||
					(chan_op && !en_ok_r)) begin
				res_valid_nxt = 1'b1;
				res_data_nxt  = '0;
				refused_nxt   = 1'b1;
			end else begin
				req_valid_nxt = 1'b1;
				req_op_nxt    = cmd_op;
				req_data_nxt  = cmd_data;
				busy_nxt      = 1'b1;
				if (cmd_op == dma_ctl_pkg::OP_BASE_SET)
					base_ok_nxt = 1'b1;
				if (cmd_op == dma_ctl_pkg::OP_CTL_EN)
					en_ok_nxt = 1'b1;
				if (cmd_op == dma_ctl_pkg::OP_CTL_DIS)
					en_ok_nxt = 1'b0;
			end
		end
	end

	// registers only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			req_valid_r <= 1'b0;
			req_op_r    <= dma_ctl_pkg::OP_NOP;
			req_data_r  <= '0;
			busy_r      <= 1'b0;
			base_ok_r   <= 1'b0;
			en_ok_r     <= 1'b0;
			res_valid_r <= 1'b0;
			res_data_r  <= '0;
			refused_r   <= 1'b0;
		end else if (ce) begin
			req_valid_r <= req_valid_nxt;
			req_op_r    <= req_op_nxt;
			req_data_r  <= req_data_nxt;
			busy_r      <= busy_nxt;
			base_ok_r   <= base_ok_nxt;
			en_ok_r     <= en_ok_nxt;
			res_valid_r <= res_valid_nxt;
			res_data_r  <= res_data_nxt;
			refused_r   <= refused_nxt;
		end
	end
endmodule : dma_ctl_host

// >>> tb/dma_table_irq_control_props.sv
// link checker for the dma control link between host end and device end
module dma_table_irq_control_props (
	input wire logic             core_clk,
	input wire logic             rst_n,
	input wire logic             req_valid,
	input wire logic             req_ready,
	input wire dma_ctl_pkg::op_t req_op,
	input wire logic [31:0]      req_data,
	input wire logic             rsp_valid,
	input wire logic [31:0]      rsp_data
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// last base taken on the link, aligned the way the pointer stores it
	logic [31:0] base_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			base_r <= 32'h0000_0000;
		else if (req_valid && req_ready && req_op == dma_ctl_pkg::OP_BASE_SET)
			base_r <= req_data & 32'hFFFF_FC00;
	end

	property p_take_rsp;
		req_valid && req_ready |=> rsp_valid;
	endproperty
	a_take_rsp: assert property (p_take_rsp)
		else $error("no answer one cycle after a taken command");
	property p_rsp_pulse;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("answer strobe longer than one cycle");
	property p_rsp_cause;
		rsp_valid |-> $past(req_valid && req_ready);
	endproperty
	a_rsp_cause: assert property (p_rsp_cause)
		else $error("answer without a taken command");
	// enable query answers a single bit, upper bits stay clear
	property p_isen_bit;
		rsp_valid && $past(req_op) == dma_ctl_pkg::OP_CH_ISEN
			|-> rsp_data[31:1] == 31'h0000_0000;
	endproperty
	a_isen_bit: assert property (p_isen_bit)
		else $error("channel enable answer wider than one bit");
	property p_offer_ready;
		$rose(req_valid) |-> req_ready;
	endproperty
	a_offer_ready: assert property (p_offer_ready)
		else $error("command offered while device busy");
	property p_base_get;
		rsp_valid && $past(req_op) == dma_ctl_pkg::OP_BASE_GET
			|-> rsp_data == base_r && rsp_data[9:0] == 10'h000;
	endproperty
	a_base_get: assert property (p_base_get)
		else $error("base read back wrong or unaligned");
	property p_alt_get;
		rsp_valid && $past(req_op) == dma_ctl_pkg::OP_ALT_GET
			|-> rsp_data == base_r + 32'h0000_0200;
	endproperty
	a_alt_get: assert property (p_alt_get)
		else $error("alternate base not upper half of table");
	property p_base_set_aligned;
		req_valid && req_op == dma_ctl_pkg::OP_BASE_SET
			|-> req_data[9:0] == 10'h000;
	endproperty
	a_base_set_aligned: assert property (p_base_set_aligned)
		else $error("unaligned base sent on the link");

	c_base: cover property (rsp_valid &&
		$past(req_op) == dma_ctl_pkg::OP_BASE_GET);
	c_alt: cover property (rsp_valid &&
		$past(req_op) == dma_ctl_pkg::OP_ALT_GET);
	c_clr: cover property (req_valid && req_op == dma_ctl_pkg::OP_ERR_CLR);
endmodule : dma_table_irq_control_props

// >>> tb/dma_table_irq_control_bench.sv
// bench: host end and device end joined, memory and peripherals modelled
module dma_table_irq_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// full 1024-byte table reserved: every channel, both halves
	localparam logic [31:0] BASE = 32'h0000_1400;
	logic             core_clk = 1'b0;
	logic             rst_n = 1'b0;
	logic             ce = 1'b1;
	logic             cmd_valid = 1'b0;
	logic             cmd_ready, res_valid, res_refused;
	dma_ctl_pkg::op_t cmd_op = dma_ctl_pkg::OP_NOP;
	logic [31:0]      cmd_data = 32'h0000_0000;
	logic [31:0]      res_data, got, chan_req = 32'h0000_0000;
	logic [31:0]      mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
	logic [31:0]      periph_done;
	logic             mem_rd_req, mem_wr_req, sw_irq, err_irq, refused;
	logic             rd_go = 1'b0;
	logic             wr_go = 1'b1;
	logic             mem_err = 1'b0;
	logic [31:0]      mem [0:1023];
	int               errors = 0;
	int               compares = 0;
	int               rd_cnt = 0;
	int               n0;

	always #2.5 core_clk = ~core_clk;

	dma_link_if link();
	dma_ctl_host dma_ctl_host_i (.core_clk, .rst_n, .ce, .link(link),
		.cmd_valid, .cmd_ready, .cmd_op, .cmd_data, .res_valid, .res_data,
		.res_refused);
	dma_ctl_device dma_ctl_device_i (.core_clk, .rst_n, .ce, .link(link),
		.chan_req, .mem_rd_req, .mem_rd_addr, .mem_rd_valid(rd_go),
		.mem_rd_data, .mem_wr_req, .mem_wr_addr, .mem_wr_data,
		.mem_wr_ready(wr_go), .mem_err, .sw_irq, .err_irq, .periph_done);
	dma_table_irq_control_props props_i (.core_clk, .rst_n,
		.req_valid(link.req_valid), .req_ready(link.req_ready),
		.req_op(link.req_op), .req_data(link.req_data),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

	// memory answers every other cycle; an idle read bus shows no stale word
	assign mem_rd_data = mem_rd_req ? mem[mem_rd_addr[11:2]] : ~mem_rd_addr;
	always @(posedge core_clk) begin
		#1;
		rd_go = ~rd_go;
	end
	always @(posedge core_clk) begin
		if (mem_rd_req && rd_go)
			rd_cnt <= rd_cnt + 1;
		if (mem_wr_req && wr_go)
			mem[mem_wr_addr[11:2]] <= mem_wr_data;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// one command through the host end; caller stands 1 ns after an edge
	task automatic cmd(input dma_ctl_pkg::op_t op, input logic [31:0] d);
		int n;
		n = 0;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		while (cmd_ready !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		tick(1);
		cmd_valid = 1'b0;
		n = 0;
		while (res_valid !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		chk({31'h0, res_valid}, 32'h0000_0001);
		got = res_data;
		refused = res_refused;
	endtask : cmd

	task automatic put(input int ch, input logic [31:0] s, input logic [31:0] d,
			input logic [31:0] c);
		mem[(BASE[11:2] + ch * 4) % 1024] = s;
		mem[(BASE[11:2] + ch * 4 + 1) % 1024] = d;
		mem[(BASE[11:2] + ch * 4 + 2) % 1024] = c;
	endtask : put

	task automatic wait_done(input int bit_no);
		int n;
		n = 0;
		while (periph_done[bit_no] !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
	endtask : wait_done

	task automatic t_reset;
		cmd(dma_ctl_pkg::OP_BASE_GET, 32'h0000_0000);
		chk(got, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_ERR_GET, 32'h0000_0000);
		chk(got, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_INT_GET, 32'h0000_0000);
		chk(got, 32'h0000_0000);
	endtask : t_reset

	task automatic t_base;
		cmd(dma_ctl_pkg::OP_CTL_EN, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_CH_EN, 32'h0000_001E);
		chk({31'h0, refused}, 32'h0000_0001);
		cmd(dma_ctl_pkg::OP_BASE_SET, BASE | 32'h0000_0100);
		chk({31'h0, refused}, 32'h0000_0001);
		cmd(dma_ctl_pkg::OP_BASE_SET, BASE);
		chk({31'h0, refused}, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_BASE_GET, 32'h0000_0000);
		chk(got, BASE);
		cmd(dma_ctl_pkg::OP_ALT_GET, 32'h0000_0000);
		chk(got, BASE + 32'h0000_0200);
	endtask : t_base

	// 40 auto words with writes stalled: the buffer fills and refuses
	task automatic t_auto;
		int n;
		for (int i = 0; i < 40; i++)
			mem[64 + i] = 32'hA5A5_0000 + i;
		put(30, 32'h0000_0100, 32'h0000_0300, 32'h0000_0272);
		wr_go = 1'b0;
		cmd(dma_ctl_pkg::OP_CH_EN, 32'h0000_001E);
		n0 = rd_cnt;
		cmd(dma_ctl_pkg::OP_CH_REQ, 32'h0000_001E);
		tick(150);
		chk(rd_cnt - n0, 35);
		wr_go = 1'b1;
		n = 0;
		while (sw_irq !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
		chk({31'h0, sw_irq}, 32'h0000_0001);
		for (int i = 0; i < 40; i++)
			chk(mem[192 + i], 32'hA5A5_0000 + i);
		chk(mem[BASE[11:2] + 122], 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_CH_ISEN, 32'h0000_001E);
		chk(got, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_INT_GET, 32'h0000_0000);
		chk(got, 32'h4000_0000);
		cmd(dma_ctl_pkg::OP_INT_CLR, 32'hBFFF_FFFF);
		chk({31'h0, sw_irq}, 32'h0000_0001);
		cmd(dma_ctl_pkg::OP_INT_CLR, 32'h4000_0000);
		chk({31'h0, sw_irq}, 32'h0000_0000);
	endtask : t_auto

	// basic transfer paced by a peripheral request line
	task automatic t_periph;
		// destination kept clear of earlier copies so a miss shows
		put(3, 32'h0000_0180, 32'h0000_03A0, 32'h0000_0011);
		cmd(dma_ctl_pkg::OP_CH_EN, 32'h0000_0003);
		chan_req = 32'h0000_0008;
		wait_done(3);
		chk({31'h0, periph_done[3]}, 32'h0000_0001);
		chk({31'h0, sw_irq}, 32'h0000_0000);
		chan_req = 32'h0000_0000;
		chk(mem[232], 32'hA5A5_0020);
		chk(mem[233], 32'hA5A5_0021);
		cmd(dma_ctl_pkg::OP_INT_GET, 32'h0000_0000);
		chk(got, 32'h0000_0008);
		cmd(dma_ctl_pkg::OP_INT_CLR, 32'h0000_0008);
	endtask : t_periph

	// bus error in mid-transfer, then cleared by software
	task automatic t_error;
		put(5, 32'h0000_0100, 32'h0000_0380, 32'h0000_0072);
		cmd(dma_ctl_pkg::OP_CH_EN, 32'h0000_0005);
		cmd(dma_ctl_pkg::OP_CH_REQ, 32'h0000_0005);
		tick(6);
		mem_err = 1'b1;
		tick(1);
		mem_err = 1'b0;
		tick(2);
		chk({31'h0, err_irq}, 32'h0000_0001);
		chk({31'h0, sw_irq}, 32'h0000_0000);
		cmd(dma_ctl_pkg::OP_ERR_GET, 32'h0000_0000);
		chk({31'h0, |got}, 32'h0000_0001);
		cmd(dma_ctl_pkg::OP_ERR_CLR, 32'h0000_0000);
		chk({31'h0, err_irq}, 32'h0000_0000);
	endtask : t_error

	// global disable holds off a requested channel until re-enabled
	task automatic t_global;
		put(7, 32'h0000_0100, 32'h0000_03C0, 32'h0000_0011);
		cmd(dma_ctl_pkg::OP_CH_EN, 32'h0000_0007);
		cmd(dma_ctl_pkg::OP_CTL_DIS, 32'h0000_0000);
		chan_req = 32'h0000_0080;
		n0 = rd_cnt;
		tick(40);
		chk(rd_cnt - n0, 0);
		cmd(dma_ctl_pkg::OP_CTL_EN, 32'h0000_0000);
		// frozen clock enable: pending work asks nothing of memory
		ce = 1'b0;
		n0 = rd_cnt;
		tick(20);
		chk(rd_cnt - n0, 0);
		ce = 1'b1;
		wait_done(7);
		chk({31'h0, periph_done[7]}, 32'h0000_0001);
		chan_req = 32'h0000_0000;
		chk(mem[241], 32'hA5A5_0001);
	endtask : t_global

	task automatic end_of_test;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		#(5 * 20000);
		errors++;
		end_of_test();
	end

	initial begin
		tick(10);
		rst_n = 1'b1;
		t_reset();
		t_base();
		t_auto();
		t_periph();
		t_error();
		t_global();
		end_of_test();
	end
endmodule : dma_table_irq_control_bench
